/* File: byte_op_pkg.sv */
package byte_op_pkg;
	localparam int INSTR_W       = 14;
	localparam int FADDR_W       = 7;
	localparam int DATA_W        = 8;
	localparam int LIT8_W        = 8;
	localparam int LIT11_W       = 11;
	localparam int GRP_HI        = 13;
	localparam int GRP_LO        = 12;
	localparam int OPC_HI        = 11;
	localparam int OPC_LO        = 8;
	localparam int DEST_BIT      = 7;
	localparam int BSEL_HI       = 9;
	localparam int BSEL_LO       = 7;
	localparam int BSUB_HI       = 11;
	localparam int BSUB_LO       = 10;
	localparam int CALL_SEL_BIT  = 11;
	localparam int FLAG_C        = 0;
	localparam int FLAG_DIGIT    = 1;
	localparam int FLAG_Z        = 2;
	localparam logic [1:0] GRP_BYTE    = 2'h0;
	localparam logic [1:0] GRP_BIT     = 2'h1;
	localparam logic [1:0] GRP_CTRL    = 2'h2;
	localparam logic [3:0] OP_STORE    = 4'h0;
	localparam logic [3:0] OP_CLEAR    = 4'h1;
	localparam logic [3:0] OP_DEC      = 4'h3;
	localparam logic [3:0] OP_OR       = 4'h4;
	localparam logic [3:0] OP_AND      = 4'h5;
	localparam logic [3:0] OP_ADD      = 4'h7;
	localparam logic [3:0] OP_MOVE     = 4'h8;
	localparam logic [3:0] OP_COMP     = 4'h9;
	localparam logic [3:0] OP_INC      = 4'hA;
	localparam logic [3:0] OP_DECSKIP  = 4'hB;
	localparam logic [3:0] OP_RRC      = 4'hC;
	localparam logic [3:0] OP_RLC      = 4'hD;
	localparam logic [3:0] OP_INCSKIP  = 4'hF;
	localparam logic [1:0] BOP_CLR     = 2'h0;
	localparam logic [1:0] BOP_SET     = 2'h1;
	localparam logic [1:0] BOP_SKIPCLR = 2'h2;
	localparam logic [1:0] BOP_SKIPSET = 2'h3;
	localparam int PHASES_PER_CYCLE    = 4;
	localparam logic [1:0] PHASE_LAST  = 2'(PHASES_PER_CYCLE - 1);
	localparam logic [1:0] PHASE_READ  = 2'h1;
	localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
	localparam logic [2:0]        FLAGS_RESET = 3'h0;
	typedef enum logic [1:0] {ST_EXEC, ST_FILL} seq_state_type;
endpackage

/* File: byte_op_instruction_decoder.sv */
`timescale 1ns/10ps
module byte_op_instruction_decoder (
	input  wire logic                                 clk,          // 100 MHz oscillator
	input  wire logic                                 rst,          // async, active high
	input  wire logic [byte_op_pkg::INSTR_W-1:0]      instrWord,    // word from program memory
	input  wire logic [byte_op_pkg::DATA_W-1:0]       fileRdData,   // file register read value
	input  wire logic [byte_op_pkg::DATA_W-1:0]       pinRdData,    // pin levels of addressed port
	input  wire logic                                 fileIsPort,   // addressed register is an I/O port
	input  wire logic                                 fileIsTimer,  // addressed register is timer_zero_count
	input  wire logic                                 prescToTimer, // prescaler assigned to timer zero
	output logic                                      fetchStb,     // take next word, one cycle
	output logic      [byte_op_pkg::FADDR_W-1:0]      fileAddr,     // file operand address
	output logic      [byte_op_pkg::DATA_W-1:0]       fileWrData,   // write data to file
	output logic                                      fileWrEn,     // file write pulse
	output logic      [byte_op_pkg::DATA_W-1:0]       accOut,       // accumulator value
	output logic      [2:0]                           flagsOut,     // {zero, digit carry, carry}
	output logic                                      branchStb,    // jump or call pulse
	output logic                                      callStb,      // call pulse (push return)
	output logic      [byte_op_pkg::LIT11_W-1:0]      branchTarget, // eleven-bit target
	output logic      [byte_op_pkg::LIT8_W-1:0]       literalOut,   // eight-bit literal field
	output logic                                      prescClrStb,  // clear shared prescaler
	output logic                                      fillCycle     // high during no-op second cycle
);
	import byte_op_pkg::*;

	logic [1:0]                phase_r, phase_nxt;
	seq_state_type             state_r, state_nxt;
	logic [INSTR_W-1:0]        ir_r, ir_nxt;
	logic [DATA_W-1:0]         opnd_r, opnd_nxt;
	logic [DATA_W-1:0]         acc_r, acc_nxt;
	logic [2:0]                flags_r, flags_nxt;
	logic [FADDR_W-1:0]        addr_r, addr_nxt;
	logic [DATA_W-1:0]         wdata_r, wdata_nxt;
	logic                      wen_r, wen_nxt;
	logic                      fetch_r, fetch_nxt;
	logic                      br_r, br_nxt;
	logic                      call_r, call_nxt;
	logic [LIT11_W-1:0]        tgt_r, tgt_nxt;
	logic [LIT8_W-1:0]         lit_r, lit_nxt;
	logic                      presc_r, presc_nxt;
	logic                      fill_r, fill_nxt;

	// zero test used by several operations
	function automatic logic isZero(input logic [DATA_W-1:0] v);
		return v == '0;
	endfunction

	// decode fields straight from the latched word
	logic [1:0]        grp;
	logic [3:0]        opc;
	logic              dest;
	logic [2:0]        bsel;
	logic [1:0]        bsub;
	assign grp  = ir_r[GRP_HI:GRP_LO];
	assign opc  = ir_r[OPC_HI:OPC_LO];
	assign dest = ir_r[DEST_BIT];
	assign bsel = ir_r[BSEL_HI:BSEL_LO];
	assign bsub = ir_r[BSUB_HI:BSUB_LO];

	// sequencer and execute: phase 0 latches word, phase 1 reads, phase 3 commits
	always_comb begin
		logic [DATA_W-1:0] res;
		logic [DATA_W:0]   sum;
		logic [4:0]        nib;
		logic              wrRes;
		logic              skip;
		res        = opnd_r;
		sum        = '0;
		nib        = '0;
		wrRes      = 1'b0;
		skip       = 1'b0;
		phase_nxt  = phase_r + 2'h1;
		state_nxt  = state_r;
		ir_nxt     = ir_r;
		opnd_nxt   = opnd_r;
		acc_nxt    = acc_r;
		flags_nxt  = flags_r;
		addr_nxt   = addr_r;
		wdata_nxt  = wdata_r;
		wen_nxt    = 1'b0;
		fetch_nxt  = 1'b0;
		br_nxt     = 1'b0;
		call_nxt   = 1'b0;
		tgt_nxt    = tgt_r;
		lit_nxt    = lit_r;
		presc_nxt  = 1'b0;
		if (phase_r == 2'h0) begin
			ir_nxt   = instrWord;
			addr_nxt = instrWord[FADDR_W-1:0];
			lit_nxt  = instrWord[LIT8_W-1:0];
			tgt_nxt  = instrWord[LIT11_W-1:0];
		end else if (phase_r == PHASE_READ) begin
			// I/O ports are read from the pins, not the output latch
			opnd_nxt = fileIsPort ? pinRdData : fileRdData;
		end else if (phase_r == PHASE_LAST) begin
			fetch_nxt = 1'b1;
			if (state_r == ST_FILL) begin
				state_nxt = ST_EXEC;
			end else if (grp == GRP_BYTE) begin
				case (opc)
					OP_STORE: begin
						// low bits are don't-care in the no-operation form
						if (dest) begin
							res      = acc_r;
							wen_nxt  = 1'b1;
						end
					end
					OP_CLEAR: begin
						res = '0;
						flags_nxt[FLAG_Z] = 1'b1;
						if (dest) wen_nxt = 1'b1;
						else acc_nxt = '0;
					end
					OP_ADD: begin
						sum = {1'b0, acc_r} + {1'b0, opnd_r};
						nib = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};
						res = sum[DATA_W-1:0];
						flags_nxt[FLAG_C]  = sum[DATA_W];
						flags_nxt[FLAG_DIGIT] = nib[4];
						flags_nxt[FLAG_Z]  = isZero(res);
						wrRes = 1'b1;
					end
					OP_OR, OP_AND, OP_COMP, OP_DEC, OP_INC, OP_MOVE: begin
						case (opc)
							OP_OR:   res = acc_r | opnd_r;
							OP_AND:  res = acc_r & opnd_r;
							OP_COMP: res = ~opnd_r;
							OP_DEC:  res = opnd_r - 8'h01;
							OP_INC:  res = opnd_r + 8'h01;
							default: res = opnd_r;
						endcase
						flags_nxt[FLAG_Z] = isZero(res);
						wrRes = 1'b1;
					end
					OP_DECSKIP, OP_INCSKIP: begin
						res   = (opc == OP_INCSKIP) ? opnd_r + 8'h01 : opnd_r - 8'h01;
						skip  = isZero(res);
						wrRes = 1'b1;
					end
					OP_RLC: begin
						res = {opnd_r[DATA_W-2:0], flags_r[FLAG_C]};
						flags_nxt[FLAG_C] = opnd_r[DATA_W-1];
						wrRes = 1'b1;
					end
					OP_RRC: begin
						res = {flags_r[FLAG_C], opnd_r[DATA_W-1:1]};
						flags_nxt[FLAG_C] = opnd_r[0];
						wrRes = 1'b1;
					end
					default: ;
				endcase
				if (wrRes) begin
					if (dest) wen_nxt = 1'b1;
					else acc_nxt = res;
				end
				wdata_nxt = res;
				presc_nxt = wen_nxt && fileIsTimer && prescToTimer;
			end else if (grp == GRP_BIT) begin
				res = opnd_r;
				case (bsub)
					BOP_CLR: begin
						res[bsel] = 1'b0;
						wen_nxt   = 1'b1;
					end
					BOP_SET: begin
						res[bsel] = 1'b1;
						wen_nxt   = 1'b1;
					end
					BOP_SKIPCLR: skip = !opnd_r[bsel];
					default:     skip = opnd_r[bsel];
				endcase
				wdata_nxt = res;
				presc_nxt = wen_nxt && fileIsTimer && prescToTimer;
			end else if (grp == GRP_CTRL) begin
				br_nxt   = 1'b1;
				call_nxt = !ir_r[CALL_SEL_BIT];
				skip     = 1'b1;
			end
			if (skip) state_nxt = ST_FILL;
		end
		fill_nxt = (state_nxt == ST_FILL);                // registered so the pin leaves a flip-flop
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= 2'h0;
			state_r <= ST_EXEC;
			ir_r    <= '0;
			opnd_r  <= '0;
			acc_r   <= ACC_RESET;
			flags_r <= FLAGS_RESET;
			addr_r  <= '0;
			wdata_r <= '0;
			wen_r   <= 1'b0;
			fetch_r <= 1'b0;
			br_r    <= 1'b0;
			call_r  <= 1'b0;
			tgt_r   <= '0;
			lit_r   <= '0;
			presc_r <= 1'b0;
			fill_r  <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			state_r <= state_nxt;
			ir_r    <= ir_nxt;
			opnd_r  <= opnd_nxt;
			acc_r   <= acc_nxt;
			flags_r <= flags_nxt;
			addr_r  <= addr_nxt;
			wdata_r <= wdata_nxt;
			wen_r   <= wen_nxt;
			fetch_r <= fetch_nxt;
			br_r    <= br_nxt;
			call_r  <= call_nxt;
			tgt_r   <= tgt_nxt;
			lit_r   <= lit_nxt;
			presc_r <= presc_nxt;
			fill_r  <= fill_nxt;
		end
	end

	// outputs come straight from flip-flops
	assign fetchStb     = fetch_r;
	assign fileAddr     = addr_r;
	assign fileWrData   = wdata_r;
	assign fileWrEn     = wen_r;
	assign accOut       = acc_r;
	assign flagsOut     = flags_r;
	assign branchStb    = br_r;
	assign callStb      = call_r;
	assign branchTarget = tgt_r;
	assign literalOut   = lit_r;
	assign prescClrStb  = presc_r;
	assign fillCycle    = fill_r;

	// commits happen only on the phase after the last one
	property p_commit_phase;
		@(posedge clk) disable iff (rst) fileWrEn |-> $past(phase_r) == PHASE_LAST;
	endproperty
	a_commit_phase: assert property (p_commit_phase) else $error("write outside commit slot");

	property p_fill_quiet;
		@(posedge clk) disable iff (rst)
			(state_r == ST_FILL && phase_r == PHASE_LAST) |=> !fileWrEn && $stable(accOut) && $stable(flagsOut);
	endproperty
	a_fill_quiet: assert property (p_fill_quiet) else $error("write during fill cycle");

	property p_four_phases;
		@(posedge clk) disable iff (rst) fetchStb |=> !fetchStb [*3] ##1 fetchStb;
	endproperty
	a_four_phases: assert property (p_four_phases) else $error("cycle not four periods");

	property p_branch_fill;
		@(posedge clk) disable iff (rst) branchStb |-> fillCycle;
	endproperty
	a_branch_fill: assert property (p_branch_fill) else $error("transfer without second cycle");

	property p_skip_flags;
		@(posedge clk) disable iff (rst)
			(phase_r == PHASE_LAST && state_r == ST_EXEC && grp == GRP_BYTE
			 && (opc == OP_DECSKIP || opc == OP_INCSKIP)) |=> $stable(flagsOut);
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("skip op changed flags");

	property p_dest_acc;
		@(posedge clk) disable iff (rst)
			(phase_r == PHASE_LAST && state_r == ST_EXEC && grp == GRP_BYTE && !dest) |=> !fileWrEn;
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("file written with d clear");

	property p_rotate_carry;
		@(posedge clk) disable iff (rst)
			(phase_r == PHASE_LAST && state_r == ST_EXEC && grp == GRP_BYTE && opc == OP_RLC)
			|=> flagsOut[FLAG_C] == $past(opnd_r[DATA_W-1]) && flagsOut[FLAG_Z] == $past(flags_r[FLAG_Z]);
	endproperty
	a_rotate_carry: assert property (p_rotate_carry) else $error("rotate flag update wrong");

	property p_clear_zero;
		@(posedge clk) disable iff (rst)
			(phase_r == PHASE_LAST && state_r == ST_EXEC && grp == GRP_BYTE && opc == OP_CLEAR)
			|=> flagsOut[FLAG_Z];
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not set zero");

	property p_presc;
		@(posedge clk) disable iff (rst) prescClrStb |-> fileWrEn;
	endproperty
	a_presc: assert property (p_presc) else $error("prescaler clear without write");

	// the other direction: a timer write with the prescaler assigned there must clear it
	property p_presc_on_timer;
		@(posedge clk) disable iff (rst)
			(fileWrEn && $past(fileIsTimer) && $past(prescToTimer)) |-> prescClrStb;
	endproperty
	a_presc_on_timer: assert property (p_presc_on_timer) else $error("timer write kept prescaler");

	// a store with the destination bit clear is the no-operation form, whatever its low bits hold
	property p_nop_quiet;
		@(posedge clk) disable iff (rst)
			(phase_r == PHASE_LAST && state_r == ST_EXEC && grp == GRP_BYTE && opc == OP_STORE && !dest)
			|=> !fileWrEn && $stable(accOut) && $stable(flagsOut);
	endproperty
	a_nop_quiet: assert property (p_nop_quiet) else $error("no-operation word changed state");

	// logic operations may move the zero flag only
	property p_logic_zero_only;
		@(posedge clk) disable iff (rst)
			(phase_r == PHASE_LAST && state_r == ST_EXEC && grp == GRP_BYTE && (opc == OP_OR || opc == OP_AND))
			|=> flagsOut[FLAG_C] == $past(flags_r[FLAG_C]) && flagsOut[FLAG_DIGIT] == $past(flags_r[FLAG_DIGIT]);
	endproperty
	a_logic_zero_only: assert property (p_logic_zero_only) else $error("logic op touched carry");

	// accumulator and flags move only on a commit edge, never in between
	property p_state_between;
		@(posedge clk) disable iff (rst) !fetchStb |-> $stable(accOut) && $stable(flagsOut);
	endproperty
	a_state_between: assert property (p_state_between) else $error("state changed off commit");
endmodule

/* File: prog_mem_model.sv */
`timescale 1ns/10ps
// program memory beside the decoder: one word per instruction slot, advanced by each commit
module prog_mem_model (
	input  wire logic                             clk,      // oscillator
	input  wire logic                             rst,      // async reset
	input  wire logic                             fetchStb, // decoder consumed the word
	output logic      [byte_op_pkg::INSTR_W-1:0]  instrWord // word at the read pointer plus fetchStb
);
	import byte_op_pkg::*;
	logic [INSTR_W-1:0] mem [0:511];
	int unsigned        ptr;
	// the pointer only moves on the phase-0 edge, so the next word is shown ahead while the strobe stands
	always @(posedge clk or posedge rst) begin
		if (rst)
			ptr <= 0;
		else if (fetchStb)
			ptr <= ptr + 1;
	end
	assign instrWord = mem[(ptr + 32'(fetchStb)) % 512];
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
	import byte_op_pkg::*;
	localparam int NSLOT = 400;
	// directed words {word, operand}: don't-care forms, skips with fill slots, every byte and bit operation, jumps
	localparam logic [21:0] DIR [26] = '{22'h077F9C, 22'h008500, 22'h000000, 22'h006000, 22'h040521,
		22'h0505F0, 22'h017F00, 22'h0B8101, 22'h2FFF00, 22'h0F00FF, 22'h018000, 22'h0F8005, 22'h0D8081,
		22'h0C0001, 22'h09805A, 22'h030000, 22'h0A80FF, 22'h080000, 22'h1385FF, 22'h140500, 22'h1800FE,
		22'h010000, 22'h1F8080, 22'h2ABC00, 22'h2ABC00, 22'h3FFF00};
	logic                clk, rst, fileIsPort, fileIsTimer, prescToTimer;
	logic [INSTR_W-1:0]  instrWord;
	logic [DATA_W-1:0]   fileRdData, pinRdData, fileWrData, accOut, mAcc;
	logic [FADDR_W-1:0]  fileAddr;
	logic [2:0]          flagsOut, mFlags;
	logic                fetchStb, fileWrEn, branchStb, callStb, prescClrStb, fillCycle, mFill;
	logic [LIT11_W-1:0]  branchTarget;
	logic [LIT8_W-1:0]   literalOut;
	logic [INSTR_W-1:0]  wq [0:511];
	logic [7:0]          frq [0:511];
	logic [7:0]          prq [0:511];
	logic [2:0]          selq [0:511]; // {port, timer, prescaler to timer}
	int                  fail_count, checks_done, drvSlot, chkSlot, cyc, lastCyc;

	byte_op_instruction_decoder uut (.clk(clk), .rst(rst), .instrWord(instrWord), .fileRdData(fileRdData),
		.pinRdData(pinRdData), .fileIsPort(fileIsPort), .fileIsTimer(fileIsTimer), .prescToTimer(prescToTimer),
		.fetchStb(fetchStb), .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn), .accOut(accOut),
		.flagsOut(flagsOut), .branchStb(branchStb), .callStb(callStb), .branchTarget(branchTarget),
		.literalOut(literalOut), .prescClrStb(prescClrStb), .fillCycle(fillCycle));
	prog_mem_model pm (.clk(clk), .rst(rst), .fetchStb(fetchStb), .instrWord(instrWord));

	always #5 clk = ~clk;

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// operands for a slot stay put for its whole cycle, so every sampling phase sees them
	task automatic put(input int s);
		fileRdData <= frq[s];
		pinRdData <= prq[s];
		{fileIsPort, fileIsTimer, prescToTimer} <= selq[s];
	endtask

	// reference model of one committed slot, then comparison of all results
	task automatic score(input int s);
		logic [13:0] w;
		logic [7:0]  op, res;
		logic [8:0]  sum;
		logic [2:0]  b;
		logic        ok, wr, skip, br, fill;
		w = wq[s];
		op = selq[s][2] ? prq[s] : frq[s];
		sum = {1'b0, mAcc} + {1'b0, op};
		b = w[BSEL_HI:BSEL_LO];
		res = 8'h00;
		{ok, wr, skip, br} = 4'h0;
		fill = mFill;
		if (fill) begin
			mFill = 1'b0;
		end else if (w[13:12] == GRP_BYTE) begin
			ok = 1'b1;
			case (w[11:8])
				OP_STORE: begin res = mAcc; ok = w[7]; end
				OP_CLEAR: res = 8'h00;
				OP_DEC, OP_DECSKIP: res = op - 8'h01;
				OP_INC, OP_INCSKIP: res = op + 8'h01;
				OP_OR: res = mAcc | op;
				OP_AND: res = mAcc & op;
				OP_ADD: res = sum[7:0];
				OP_MOVE: res = op;
				OP_COMP: res = ~op;
				OP_RLC: begin res = {op[6:0], mFlags[FLAG_C]}; mFlags[FLAG_C] = op[7]; end
				OP_RRC: begin res = {mFlags[FLAG_C], op[7:1]}; mFlags[FLAG_C] = op[0]; end
				default: ok = 1'b0;
			endcase
			case (w[11:8])
				OP_CLEAR, OP_DEC, OP_INC, OP_OR, OP_AND, OP_MOVE, OP_COMP: mFlags[FLAG_Z] = (res == 8'h00);
				OP_ADD: mFlags = {res == 8'h00, (mAcc[3:0] + op[3:0]) > 5'h0F, sum[8]};
				OP_DECSKIP, OP_INCSKIP: skip = (res == 8'h00);
				default: ;
			endcase
			wr = ok & w[DEST_BIT];
			if (ok && !w[DEST_BIT])
				mAcc = res;
		end else if (w[13:12] == GRP_BIT) begin
			case (w[BSUB_HI:BSUB_LO])
				BOP_CLR: begin res = op & ~(8'h01 << b); wr = 1'b1; end
				BOP_SET: begin res = op | (8'h01 << b); wr = 1'b1; end
				BOP_SKIPCLR: skip = ~op[b];
				default: skip = op[b];
			endcase
		end else if (w[13:12] == GRP_CTRL) begin
			br = 1'b1;
		end
		if (!fill)
			mFill = skip | br;
		check(11'(fileWrEn), 11'(wr), "file write");
		if (wr)
			check(11'(fileWrData), 11'(res), "write data");
		check(11'(prescClrStb), 11'(wr & selq[s][1] & selq[s][0]), "prescaler clear");
		check(11'(accOut), 11'(mAcc), "accumulator");
		check(11'(flagsOut), 11'(mFlags), "flags");
		check(11'(branchStb), 11'(br), "branch");
		check(11'(callStb), 11'(br & ~w[CALL_SEL_BIT]), "call");
		check(11'(fillCycle), 11'(mFill), "fill cycle");
		if (!fill) begin
			check(11'(fileAddr), 11'(w[6:0]), "file address");
			check(11'(literalOut), 11'(w[7:0]), "literal");
			check(branchTarget, w[10:0], "target");
		end
	endtask

	// next slot's operands go out one clock after the commit edge, on the edge that latches the next word
	always @(posedge clk) begin
		if (!rst && fetchStb === 1'b1) begin
			drvSlot <= drvSlot + 1;
			put(drvSlot + 1);
		end
	end

	// results settle by the falling edge after the commit
	always @(negedge clk) begin
		cyc++;
		if (!rst && fetchStb === 1'b1) begin
			if (chkSlot > 0)
				check(11'(cyc - lastCyc), 11'(PHASES_PER_CYCLE), "cycle length");
			lastCyc = cyc;
			score(chkSlot);
			chkSlot++;
		end
	end

	initial begin
		{clk, fail_count, checks_done, drvSlot, chkSlot, cyc, lastCyc} = '0;
		rst = 1'b1;
		{mAcc, mFlags, mFill} = {ACC_RESET, FLAGS_RESET, 1'b0};
		void'($urandom(32'h5B7F99DA));
		for (int i = 0; i < 512; i++) begin
			wq[i] = 14'($urandom);
			frq[i] = 8'($urandom);
			prq[i] = 8'($urandom);
			selq[i] = 3'($urandom);
		end
		foreach (DIR[i]) begin
			{wq[i], frq[i]} = DIR[i];
			selq[i] = 3'h0;
		end
		for (int i = 0; i < 512; i++)
			pm.mem[i] = wq[i];
		put(0);
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wait (chkSlot >= NSLOT);
		final_report();
	end

	// the run needs about four clocks per slot; allow generous slack
	initial begin
		repeat (NSLOT * 4 + 2000) @(posedge clk);
		fail_count++;
		$display("mismatch at %0t: commits stopped", $time);
		final_report();
	end
endmodule
